// ==== rtl/flash_cmd_pkg.sv ====
// Purpose: constants shared by the serial flash command core
// Assumes: 50 MHz system clock, mode 0 or 3 link
// Notes:   opcodes, status bit positions and phase encoding
package flash_cmd_pkg;

  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_VOL_ENABLE = 8'h50;
  localparam logic [7:0] OP_STAT_RD_A  = 8'h05;
  localparam logic [7:0] OP_STAT_RD_B  = 8'h35;
  localparam logic [7:0] OP_BUSY_PIN   = 8'h25;
  localparam logic [7:0] OP_STAT_WR    = 8'h01;
  localparam logic [7:0] OP_STAT_WR_HI = 8'h31;
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_FAST_READ  = 8'h0b;
  localparam logic [7:0] OP_TWO_LINE   = 8'h3b;

  // ----------------------------------------
  // status layout and reset values
  // ----------------------------------------
  localparam int          BIT_WIP       = 0;
  localparam int          BIT_WEL       = 1;
  localparam int          BIT_SP_LOW    = 7;
  localparam logic [15:0] SR_WRITABLE   = 16'h7bfc;
  localparam logic [15:0] SR_RESET      = 16'h0000;

  // ----------------------------------------
  // bit counts from chip select low
  // ----------------------------------------
  localparam logic [5:0] CNT_OPC_LAST   = 6'h07;
  localparam logic [5:0] CNT_OPC_DONE   = 6'h08;
  localparam logic [5:0] CNT_ADDR_LAST  = 6'h1f;
  localparam logic [5:0] CNT_DUMMY_LAST = 6'h27;
  localparam logic [5:0] CNT_WR_ONE     = 6'h10;
  localparam logic [5:0] CNT_WR_TWO     = 6'h18;
  localparam logic [5:0] CNT_MAX        = 6'h3f;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ                    = 50;
  localparam int STATUS_WRITE_CYCLE_TIME_US = 5000;
  localparam int STATUS_WRITE_CYCLES        = STATUS_WRITE_CYCLE_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {
    PH_OPC, PH_ADDR, PH_DUMMY, PH_DATA, PH_STAT, PH_BUSY, PH_STATUS_WRITE_CMD, PH_SKIP
  } phase_t;

endpackage

// ==== rtl/flash_cmd_core.sv ====
// Purpose: status and array read command handling of a serial flash
// Assumes: link pins sampled by clk, memory array answers memData
//          combinationally from memAddr in the same clock domain
// Notes:   outputs enables are active low; one line for each port
//
// Overview of operation
// (R1) Reset loads volatile status from nonvolatile bits
// (R2) Volatile enable immediately precedes status write
// (R3) Volatile enable keeps latch, arms one write
// (R4) Status reads accepted even while busy
// (R5) Status read shifts S7 down to S0
// (R6) Status byte repeats while select stays low
// (R7) Host should poll busy before new commands
// (R8) Busy pin command drives live busy bit
// (R9) Busy pin falls at completion, never rises
// (R10) Select high ends busy pin output, hi-Z
// (R11) Opcode 01 writes one or two bytes; 31 high
// (R12) Host sets write enable before status write
// (R13) Bits 15, 10, 1, 0 never written
// (R14) Status write only at 8 or 16 bits
// (R15) Valid write runs timed cycle, clears latch
// (R16) Hardware protection ignores status writes
// (R17) Read: opcode, 24 address bits, data on falls
// (R18) Address increments per byte, wraps to zero
// (R19) Select high stops read output at once
// (R20) Array reads rejected while a cycle runs
// (R21) Fast read waits one dummy byte
// (R22) Two line read: eight dummies, two bits
// (R23) Host releases line 0 before data
// (R24) Even bits on line 0, odd on 1
// (R25) Write enable opcode sets the latch
// (R26) Msb first; cut opcode is not received
// (R27) Output hi-Z when deselected or not sending
`timescale 1ns/1ps
module flash_cmd_core
  import flash_cmd_pkg::*;
#(
  parameter int WR_CYCLES = STATUS_WRITE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        csN,
  input  wire logic        sclk,
  input  wire logic        wpN,
  input  wire logic        io0In,
  output logic             io0Out,
  output logic             io0OeN,
  output logic             io1Out,
  output logic             io1OeN,
  input  wire logic [15:0] nvStatus,
  input  wire logic        extBusy,
  output logic      [23:0] memAddr,
  input  wire logic [7:0]  memData,
  output logic      [15:0] statusVol,
  output logic             writeEnableLatch,
  output logic             writeInProgress,
  output logic             nvWrite,
  output logic      [15:0] nvWriteData
);

  localparam int TW = $clog2(WR_CYCLES + 1);

  if (WR_CYCLES < 1) begin : g_chk
    $error("WR_CYCLES must be at least one");
  end

  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  logic [1:0] rstSync_ff;
  logic       rstN;
  logic [3:0] pinS1_ff;
  logic [3:0] pinS2_ff;
  logic       sclkLast_ff;
  logic       csPrev_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstSync_ff <= 2'h0;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstN = rstSync_ff[1];

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinS1_ff    <= 4'h9;
      pinS2_ff    <= 4'h9;
      sclkLast_ff <= 1'b0;
      csPrev_ff   <= 1'b1;
    end else begin
      pinS1_ff    <= {csN, sclk, io0In, wpN};
      pinS2_ff    <= pinS1_ff;
      sclkLast_ff <= pinS2_ff[2];
      csPrev_ff   <= pinS2_ff[3];
    end
  end

  logic csHi;
  logic rise;
  logic fall;
  logic siBit;
  logic wpS;
  logic csEnd;
  assign csHi  = pinS2_ff[3];
  assign rise  = pinS2_ff[2] & ~sclkLast_ff;
  assign fall  = ~pinS2_ff[2] & sclkLast_ff;
  assign siBit = pinS2_ff[1];
  assign wpS   = pinS2_ff[0];
  assign csEnd = csHi & ~csPrev_ff;

  // ----------------------------------------
  // command state
  // ----------------------------------------
  phase_t        phase_ff,  nxt_phase;
  logic [5:0]    bitCnt_ff, nxt_bitCnt;
  logic [7:0]    shIn_ff,   nxt_shIn;
  logic [7:0]    opc_ff,    nxt_opc;
  logic [23:0]   addr_ff,   nxt_addr;
  logic [7:0]    shOut_ff,  nxt_shOut;
  logic [2:0]    pos_ff,    nxt_pos;
  logic          io0_ff,    nxt_io0;
  logic          io1_ff,    nxt_io1;
  logic          oe0N_ff,   nxt_oe0N;
  logic          oe1N_ff,   nxt_oe1N;
  logic [15:0]   wr_ff,     nxt_wr;
  logic          wel_ff,    nxt_wel;
  logic          volArm_ff, nxt_volArm;
  logic [15:0]   stat_ff,   nxt_stat;
  logic          loaded_ff, nxt_loaded;
  logic          wip_ff,    nxt_wip;
  logic [TW-1:0] timer_ff,  nxt_timer;
  logic [15:0]   pend_ff,   nxt_pend;
  logic          nvWr_ff,   nxt_nvWr;

  logic [7:0]  newByte;
  logic [7:0]  cur;
  logic [7:0]  statByte;
  logic [15:0] wrVal;
  logic [15:0] merged;
  logic        busy;
  logic        hwProt;
  logic        wrOk;
  logic        isRead;
  logic        dual;

  assign newByte  = {shIn_ff[6:0], siBit};
  assign statByte = {stat_ff[7:2], wel_ff, wip_ff};
  assign busy     = wip_ff | extBusy;
  assign hwProt   = stat_ff[BIT_SP_LOW] & ~wpS;
  assign isRead   = (newByte == OP_READ) || (newByte == OP_FAST_READ) || (newByte == OP_TWO_LINE);
  assign dual     = (opc_ff == OP_TWO_LINE);
  assign wrOk     = ((bitCnt_ff == CNT_WR_ONE) || ((bitCnt_ff == CNT_WR_TWO) && (opc_ff == OP_STAT_WR)))
                    && (volArm_ff || wel_ff) && !hwProt && !busy; // R14 R16
  always_comb begin
    wrVal = {stat_ff[15:8], wr_ff[7:0]}; // R11
    if (opc_ff == OP_STAT_WR_HI) begin
      wrVal = {wr_ff[7:0], stat_ff[7:0]}; // R11
    end else if (bitCnt_ff == CNT_WR_TWO) begin
      wrVal = {wr_ff[7:0], wr_ff[15:8]}; // R11
    end
  end
  assign merged = (stat_ff & ~SR_WRITABLE) | (wrVal & SR_WRITABLE); // R13

  always_comb begin
    nxt_phase  = phase_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_shIn   = shIn_ff;
    nxt_opc    = opc_ff;
    nxt_addr   = addr_ff;
    nxt_shOut  = shOut_ff;
    nxt_pos    = pos_ff;
    nxt_io0    = io0_ff;
    nxt_io1    = io1_ff;
    nxt_oe0N   = oe0N_ff;
    nxt_oe1N   = oe1N_ff;
    nxt_wr     = wr_ff;
    nxt_wel    = wel_ff;
    nxt_volArm = volArm_ff;
    nxt_stat   = stat_ff;
    nxt_loaded = 1'b1;
    nxt_wip    = wip_ff;
    nxt_timer  = timer_ff;
    nxt_pend   = pend_ff;
    nxt_nvWr   = 1'b0;
    cur        = (pos_ff == 3'h0) ? memData : shOut_ff;
    if (!loaded_ff) begin
      nxt_stat = nvStatus; // R1
    end
    if (wip_ff) begin
      if (timer_ff == TW'(1)) begin
        nxt_wip  = 1'b0; // R15
        nxt_wel  = 1'b0; // R15
        nxt_stat = pend_ff;
        nxt_nvWr = 1'b1;
      end else begin
        nxt_timer = timer_ff - TW'(1);
      end
    end
    if (csHi) begin
      nxt_phase  = PH_OPC;
      nxt_bitCnt = 6'h00;
      nxt_pos    = 3'h0;
      nxt_oe0N   = 1'b1; // R10 R19 R27
      nxt_oe1N   = 1'b1; // R10 R19 R27
      if (csEnd && (phase_ff == PH_OPC) && (bitCnt_ff == CNT_OPC_DONE)) begin // R26
        if (opc_ff == OP_WR_ENABLE) begin
          nxt_wel = 1'b1; // R25
        end else if (opc_ff == OP_WR_DISABLE) begin
          nxt_wel = 1'b0;
        end else if (opc_ff == OP_VOL_ENABLE) begin
          nxt_volArm = 1'b1; // R3
        end
      end
      if (csEnd && (phase_ff == PH_STATUS_WRITE_CMD)) begin
        nxt_volArm = 1'b0; // R3
        if (wrOk && volArm_ff) begin
          nxt_stat = merged; // R3
        end else if (wrOk) begin
          nxt_wip   = 1'b1; // R15
          nxt_timer = TW'(WR_CYCLES); // R15
          nxt_pend  = merged;
        end
      end
    end else begin
      if (rise) begin
        nxt_bitCnt = (bitCnt_ff == CNT_MAX) ? CNT_MAX : bitCnt_ff + 6'h01;
        nxt_shIn   = newByte; // R26
      end
      unique case (phase_ff)
        PH_OPC: begin
          if (rise && (bitCnt_ff == CNT_OPC_LAST)) begin
            nxt_opc = newByte;
            if ((newByte != OP_STAT_WR) && (newByte != OP_STAT_WR_HI)) begin
              nxt_volArm = 1'b0; // R3
            end
            if ((newByte == OP_STAT_RD_A) || (newByte == OP_STAT_RD_B)) begin
              nxt_phase = PH_STAT; // R4
            end else if (newByte == OP_BUSY_PIN) begin
              nxt_phase = PH_BUSY; // R8
              nxt_io1   = wip_ff;
              nxt_oe1N  = 1'b0;
            end else if ((newByte == OP_STAT_WR) || (newByte == OP_STAT_WR_HI)) begin
              nxt_phase = PH_STATUS_WRITE_CMD;
            end else if (isRead) begin
              nxt_phase = busy ? PH_SKIP : PH_ADDR; // R20
            end else if ((newByte != OP_WR_ENABLE) && (newByte != OP_WR_DISABLE)
                         && (newByte != OP_VOL_ENABLE)) begin
              nxt_phase = PH_SKIP;
            end
          end
        end
        PH_ADDR: begin
          if (rise) begin
            nxt_addr = {addr_ff[22:0], siBit}; // R17
            if (bitCnt_ff == CNT_ADDR_LAST) begin
              nxt_phase = (opc_ff == OP_READ) ? PH_DATA : PH_DUMMY; // R21 R22
            end
          end
        end
        PH_DUMMY: begin
          if (rise && (bitCnt_ff == CNT_DUMMY_LAST)) begin
            nxt_phase = PH_DATA; // R21 R22
          end
        end
        PH_DATA: begin
          if (fall) begin
            nxt_io1  = cur[7]; // R17
            nxt_oe1N = 1'b0;
            if (dual) begin
              nxt_io0   = cur[6]; // R24
              nxt_oe0N  = 1'b0; // R22
              nxt_shOut = {cur[5:0], 2'h0}; // R24
            end else begin
              nxt_shOut = {cur[6:0], 1'b0};
            end
            if ((dual && (pos_ff == 3'h3)) || (pos_ff == 3'h7)) begin
              nxt_pos  = 3'h0;
              nxt_addr = addr_ff + 24'h000001; // R18
            end else begin
              nxt_pos = pos_ff + 3'h1;
            end
          end
        end
        PH_STAT: begin
          if (fall) begin
            if (pos_ff == 3'h0) begin
              nxt_io1   = statByte[7]; // R5
              nxt_shOut = {statByte[6:0], 1'b0};
            end else begin
              nxt_io1   = shOut_ff[7];
              nxt_shOut = {shOut_ff[6:0], 1'b0};
            end
            nxt_oe1N = 1'b0;
            nxt_pos  = pos_ff + 3'h1; // R6
          end
        end
        PH_BUSY: begin
          nxt_io1 = wip_ff; // R8 R9
        end
        PH_STATUS_WRITE_CMD: begin
          if (rise) begin
            nxt_wr = {wr_ff[14:0], siBit};
          end
        end
        PH_SKIP: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      phase_ff  <= PH_OPC;
      bitCnt_ff <= 6'h00;
      shIn_ff   <= 8'h00;
      opc_ff    <= 8'h00;
      addr_ff   <= 24'h000000;
      shOut_ff  <= 8'h00;
      pos_ff    <= 3'h0;
      io0_ff    <= 1'b0;
      io1_ff    <= 1'b0;
      oe0N_ff   <= 1'b1;
      oe1N_ff   <= 1'b1;
      wr_ff     <= 16'h0000;
      wel_ff    <= 1'b0;
      volArm_ff <= 1'b0;
      stat_ff   <= SR_RESET;
      loaded_ff <= 1'b0;
      wip_ff    <= 1'b0;
      timer_ff  <= '0;
      pend_ff   <= SR_RESET;
      nvWr_ff   <= 1'b0;
    end else begin
      phase_ff  <= nxt_phase;
      bitCnt_ff <= nxt_bitCnt;
      shIn_ff   <= nxt_shIn;
      opc_ff    <= nxt_opc;
      addr_ff   <= nxt_addr;
      shOut_ff  <= nxt_shOut;
      pos_ff    <= nxt_pos;
      io0_ff    <= nxt_io0;
      io1_ff    <= nxt_io1;
      oe0N_ff   <= nxt_oe0N;
      oe1N_ff   <= nxt_oe1N;
      wr_ff     <= nxt_wr;
      wel_ff    <= nxt_wel;
      volArm_ff <= nxt_volArm;
      stat_ff   <= nxt_stat;
      loaded_ff <= nxt_loaded;
      wip_ff    <= nxt_wip;
      timer_ff  <= nxt_timer;
      pend_ff   <= nxt_pend;
      nvWr_ff   <= nxt_nvWr;
    end
  end

  assign io0Out           = io0_ff;
  assign io0OeN           = oe0N_ff;
  assign io1Out           = io1_ff;
  assign io1OeN           = oe1N_ff;
  assign memAddr          = addr_ff;
  assign statusVol        = stat_ff;
  assign writeEnableLatch = wel_ff;
  assign writeInProgress  = wip_ff;
  assign nvWrite          = nvWr_ff;
  assign nvWriteData      = stat_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  a_status_load: assert property ($rose(loaded_ff) |-> stat_ff == $past(nvStatus)) // R1
    else $error("status copy not loaded from nonvolatile bits");
  a_vol_keeps_latch: assert property (csEnd && phase_ff == PH_OPC && bitCnt_ff == CNT_OPC_DONE // R3
    && opc_ff == OP_VOL_ENABLE && !wip_ff |=> wel_ff == $past(wel_ff) && volArm_ff)
    else $error("volatile enable touched the latch");
  a_vol_no_cycle: assert property (csEnd && phase_ff == PH_STATUS_WRITE_CMD && wrOk && volArm_ff |=> !wip_ff) // R3
    else $error("volatile write started a timed cycle");
  a_stat_while_busy: assert property (phase_ff == PH_OPC && rise && !csHi && bitCnt_ff == CNT_OPC_LAST // R4
    && newByte == OP_STAT_RD_A |=> phase_ff == PH_STAT)
    else $error("status read not accepted");
  a_busy_pin_live: assert property (phase_ff == PH_BUSY && !csHi ##1 !csHi |-> io1Out == $past(wip_ff)) // R8
    else $error("busy pin not tracking");
  a_busy_pin_mono: assert property (phase_ff == PH_BUSY && !io1_ff && !oe1N_ff |=> !io1_ff) // R9
    else $error("busy pin rose");
  a_desel_hiz: assert property (csHi |=> io0OeN && io1OeN) // R27
    else $error("output driven while deselected");
  a_wr_start: assert property (csEnd && phase_ff == PH_STATUS_WRITE_CMD && wrOk && !volArm_ff // R15
    |=> wip_ff && timer_ff == TW'(WR_CYCLES))
    else $error("status write cycle not started");
  a_wr_reject: assert property (csEnd && phase_ff == PH_STATUS_WRITE_CMD && !wrOk && !wip_ff |=> !wip_ff) // R14
    else $error("bad status write executed");
  a_wr_done: assert property ($fell(wip_ff) |-> !wel_ff && nvWr_ff) // R15
    else $error("completion did not clear latch");
  a_locked_bits: assert property (nvWr_ff |-> ((stat_ff ^ $past(stat_ff)) & ~SR_WRITABLE) == 16'h0000) // R13
    else $error("protected status bit changed");
  a_read_reject: assert property (phase_ff == PH_OPC && rise && !csHi && bitCnt_ff == CNT_OPC_LAST // R20
    && isRead && busy |=> phase_ff == PH_SKIP && (wip_ff || nvWr_ff || !$past(wip_ff)))
    else $error("array read accepted while busy");
  a_addr_step: assert property (phase_ff == PH_DATA && fall && !csHi && pos_ff == 3'h7 // R18
    |=> addr_ff == $past(addr_ff) + 24'h000001)
    else $error("address not advanced");

  c_stat_write: cover property (csEnd && phase_ff == PH_STATUS_WRITE_CMD && wrOk);
  c_busy_fall:  cover property (phase_ff == PH_BUSY && $fell(io1_ff));
  c_dual_data:  cover property (phase_ff == PH_DATA && dual && !oe0N_ff);
  c_stat_poll:  cover property (phase_ff == PH_STAT && pos_ff == 3'h7 && fall ##[1:200] phase_ff == PH_STAT && fall);

endmodule

// ==== tb/spi_host_model.sv ====
// Purpose: host side of the serial link, driven by task calls
// Assumes: mode 0, clock period of 8 clk, calls start just after an edge
// Notes:   the released data line shows the inverse of its last value
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic clk,
  output logic      csN,
  output logic      sclk,
  output logic      io0In,
  input  wire logic io0Out,
  input  wire logic io0OeN,
  input  wire logic io1Out,
  input  wire logic io1OeN
);
  logic hostOe;
  logic hostBit;

  assign io0In = !io0OeN ? io0Out : (hostOe ? hostBit : ~hostBit);

  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    hostOe = 1'b1;
    hostBit = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic select();
    csN <= 1'b0;
    tick(4);
  endtask

  // clock low before select rises, so the bit count stays on a boundary
  task automatic deselect();
    sclk <= 1'b0;
    tick(2);
    csN <= 1'b1;
    hostOe <= 1'b1;
    tick(6);
  endtask

  task automatic release0();
    hostOe <= 1'b0;
  endtask

  task automatic shift(input logic [15:0] tx, input int n, output logic [7:0] r1,
                       output logic [7:0] r0, inout logic hz);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b0;
      hostBit <= tx[15-i];
      tick(4);
      sclk <= 1'b1;
      tick(4);
      r1 = {r1[6:0], io1Out};
      r0 = {r0[6:0], io0Out};
      hz = hz & io1OeN & io0OeN;
    end
  endtask
endmodule

// ==== tb/serial_flash_status_and_read_cmds_tb.sv ====
// Purpose: self-checking bench for the flash command core
// Assumes: memory byte is address low byte xor top nibble shifted up
// Notes:   status write cycle shortened to 400 clk
`timescale 1ns/1ps
module serial_flash_status_and_read_cmds_tb
  import flash_cmd_pkg::*;
();
  typedef struct {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [7:0]  e0;
    logic [7:0]  e1;
  } row_t;

  logic        clk, nrst, csN, sclk, wpN, io0In, io0Out, io0OeN, io1Out, io1OeN;
  logic        extBusy, writeEnableLatch, writeInProgress, nvWrite, hz;
  logic [15:0] nvStatus, statusVol, nvWriteData, lastNv, got;
  logic [23:0] memAddr;
  logic [7:0]  memData, r1, r0;
  logic [14:0] nvCount;
  int          n_fail, compares;
  row_t        rows [6] = '{'{8'h03, 24'h000010, 8'h10, 8'h11}, '{8'h0b, 24'hffffff, 8'h0f, 8'h00},
                            '{8'h3b, 24'h123456, 8'h46, 8'h47}, '{8'h03, 24'ha5a5ff, 8'h5f, 8'ha0},
                            '{8'h05, 24'h0, 8'h3c, 8'h3c}, '{8'h35, 24'h0, 8'h3c, 8'h3c}};

  flash_cmd_core #(.WR_CYCLES(400)) dut (.clk(clk), .nrst(nrst), .csN(csN), .sclk(sclk), .wpN(wpN),
    .io0In(io0In), .io0Out(io0Out), .io0OeN(io0OeN), .io1Out(io1Out), .io1OeN(io1OeN),
    .nvStatus(nvStatus), .extBusy(extBusy), .memAddr(memAddr), .memData(memData),
    .statusVol(statusVol), .writeEnableLatch(writeEnableLatch), .writeInProgress(writeInProgress),
    .nvWrite(nvWrite), .nvWriteData(nvWriteData));

  spi_host_model host (.clk(clk), .csN(csN), .sclk(sclk), .io0In(io0In), .io0Out(io0Out),
    .io0OeN(io0OeN), .io1Out(io1Out), .io1OeN(io1OeN));

  assign memData = memAddr[7:0] ^ {memAddr[23:20], 4'h0};

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    nvCount = '0;
    lastNv = '0;
  end

  always @(posedge clk) begin
    if (nvWrite === 1'b1) begin
      nvCount <= nvCount + 15'h1;
      lastNv <= nvWriteData;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_sim();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] act, input logic [15:0] exp, input string what);
    compares++;
    if (act !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, act, exp);
    end
  endtask

  task automatic done(input string what);
    $display("test %s done", what);
  endtask

  task automatic wait_for(ref logic sig, input logic val);
    int k;
    for (k = 0; k < 1000 && sig !== val; k++) @(posedge clk);
    if (k == 1000) begin
      n_fail++;
      $display("unexpected at %0t: wait ran out", $time);
      end_sim();
    end
  endtask

  task automatic cmd(input logic [7:0] op, input logic [15:0] data, input int n);
    host.select();
    host.shift({op, 8'h00}, 8, r1, r0, hz);
    if (n > 0) host.shift(data, n, r1, r0, hz);
    host.deselect();
  endtask

  task automatic read_head(input logic [7:0] op, input logic [23:0] addr);
    host.select();
    host.shift({op, 8'h00}, 8, r1, r0, hz);
    host.shift(addr[23:8], 16, r1, r0, hz);
    hz = 1'b1;
    host.shift({addr[7:0], 8'h00}, 8, r1, r0, hz);
  endtask

  initial begin
    #1000000;
    n_fail++;
    $display("unexpected at %0t: run too long", $time);
    end_sim();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    wpN = 1'b1;
    extBusy = 1'b0;
    nvStatus = 16'h003c;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    check(statusVol, 16'h003c, "reset load");
    check({12'h0, writeEnableLatch, writeInProgress, io1OeN, io0OeN}, 16'h0003, "reset state");
    done("reset");
    foreach (rows[i]) begin
      if (rows[i].op inside {OP_STAT_RD_A, OP_STAT_RD_B}) begin
        host.select();
        host.shift({rows[i].op, 8'h00}, 8, r1, r0, hz);
      end else begin
        read_head(rows[i].op, rows[i].addr);
        if (rows[i].op == OP_TWO_LINE) host.release0();
        if (rows[i].op != OP_READ) host.shift(16'h0, 8, r1, r0, hz);
        check({15'h0, hz}, 16'h0001, "quiet before data");
      end
      if (rows[i].op == OP_TWO_LINE) begin
        host.shift(16'h0, 8, r1, r0, hz);
        got = {r1[7], r0[7], r1[6], r0[6], r1[5], r0[5], r1[4], r0[4],
               r1[3], r0[3], r1[2], r0[2], r1[1], r0[1], r1[0], r0[0]};
      end else begin
        host.shift(16'h0, 8, r1, r0, hz);
        got[15:8] = r1;
        host.shift(16'h0, 8, r1, r0, hz);
        got[7:0] = r1;
      end
      host.deselect();
      check(got, {rows[i].e0, rows[i].e1}, "row data");
      done("row");
    end
    cmd(OP_WR_ENABLE, 16'h0, 0);
    check({15'h0, writeEnableLatch}, 16'h0001, "latch set");
    cmd(OP_STAT_WR, 16'hff00, 8);
    check({15'h0, writeInProgress}, 16'h0001, "cycle started");
    host.select();
    host.shift({OP_STAT_RD_A, 8'h00}, 16, r1, r0, hz);
    host.deselect();
    check({8'h00, r1}, 16'h003f, "status while busy");
    host.select();
    host.shift({OP_BUSY_PIN, 8'h00}, 8, r1, r0, hz);
    host.tick(4);
    check({14'h0, io1Out, io1OeN}, 16'h0002, "busy pin high");
    wait_for(io1Out, 1'b0);
    check({15'h0, writeInProgress}, 16'h0000, "busy pin at end");
    host.deselect();
    check({15'h0, io1OeN}, 16'h0001, "busy pin released");
    check(statusVol, 16'h00fc, "one byte write");
    check({15'h0, writeEnableLatch}, 16'h0000, "latch cleared");
    check(lastNv, 16'h00fc, "stored value");
    done("status write");
    cmd(OP_STAT_WR, 16'hffff, 16);
    check({15'h0, writeInProgress}, 16'h0000, "write without latch");
    cmd(OP_WR_ENABLE, 16'h0, 0);
    cmd(OP_STAT_WR, 16'hffff, 12);
    check({15'h0, writeInProgress}, 16'h0000, "write odd count");
    cmd(OP_STAT_WR_HI, 16'hff00, 8);
    wait_for(writeInProgress, 1'b0);
    check(statusVol, 16'h7bfc, "high byte write");
    wpN <= 1'b0;
    cmd(OP_WR_ENABLE, 16'h0, 0);
    cmd(OP_STAT_WR, 16'h0000, 8);
    check({15'h0, writeInProgress}, 16'h0000, "protected write");
    check(statusVol, 16'h7bfc, "protected value");
    wpN <= 1'b1;
    done("refusals");
    host.select();
    host.shift({OP_WR_DISABLE, 8'h00}, 4, r1, r0, hz);
    host.deselect();
    check({15'h0, writeEnableLatch}, 16'h0001, "cut opcode");
    cmd(OP_WR_DISABLE, 16'h0, 0);
    cmd(OP_VOL_ENABLE, 16'h0, 0);
    check({15'h0, writeEnableLatch}, 16'h0000, "vol keeps latch");
    cmd(OP_STAT_WR, 16'h0000, 8);
    check(statusVol, 16'h7b00, "volatile write");
    check({writeInProgress, nvCount}, 16'h0002, "no timed cycle");
    done("volatile");
    extBusy <= 1'b1;
    read_head(OP_READ, 24'h000010);
    host.shift(16'h0, 8, r1, r0, hz);
    host.deselect();
    check({14'h0, hz, writeInProgress}, 16'h0002, "read while busy");
    extBusy <= 1'b0;
    read_head(OP_READ, 24'h000010);
    host.shift(16'h0, 3, r1, r0, hz);
    host.deselect();
    check({15'h0, io1OeN}, 16'h0001, "read cut short");
    done("read abort");
    end_sim();
  end
endmodule
